// ### rtl/pls_pkg.sv
// Constants and types for one step of the programmable sequence logic.
// Assumes a 20 MHz aclk and an AXI4-Lite register port with 32-bit data.
// Function
// [RULE1] Code 0 holds the step output off regardless of inputs.
// [RULE2] Code 1 passes input one straight on unchanged.
// [RULE3] Code 2 outputs input one AND input two.
// [RULE4] Code 3 outputs input one OR input two.
// [RULE5] Code 4 outputs input one XOR input two.
// [RULE6] Code 5 latch: input one sets, input two alone clears, else holds.
// [RULE7] Code 6 latch: input two clears, input one alone sets, else holds.
// [RULE8] Code 7 pulses output for one 2 ms scan on a rising input.
// [RULE9] Code 8 pulses output for one 2 ms scan on a falling input.
// [RULE10] Code 9 pulses output for one 2 ms scan on either edge.
// [RULE11] Code 10 passes input while hold is off, else keeps the last value.
// [RULE12] Code 11 counts rising inputs up; output on when count equals target.
// [RULE13] Up counter clears to zero while reset input is active.
// [RULE14] Code 12 counts rising inputs down; output on when count is zero.
// [RULE15] Down counter reloads the initial value while reset input is active.
// [RULE16] Code 13 turns output on and starts a timer when trigger rises.
// [RULE17] Timer output turns off when the period elapses, trigger regardless.
// [RULE18] Timer reset input clears elapsed time and turns output off at once.
// [RULE19] Every step is evaluated once per 2 ms scan period.
// [RULE20] Sequence enable 0 stops evaluation, 1 runs it.
// [RULE21] Count setting is the decimal setting times 100; 0.01 gives 1.
// [RULE22] Input one is data or count; input two is hold or reset.
// [RULE23] Edges compare the current scan sample with the previous scan sample.
`default_nettype none
package pls_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned SCAN_PERIOD_US = 2000;
  localparam int unsigned SCAN_CYCLES    = SCAN_PERIOD_US * 1000 / CLK_PERIOD_NS;
  // Timer settings are in hundredths of a second
  localparam int unsigned TMR_UNIT_US    = 10000;
  localparam int unsigned SCANS_PER_UNIT = TMR_UNIT_US / SCAN_PERIOD_US;
  localparam int unsigned CNT_W          = 20;
  localparam logic [7:0]  OFF_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_FUNC  = 8'h04;
  localparam logic [7:0]  OFF_SET   = 8'h08;
  localparam logic [7:0]  OFF_TMODE = 8'h0c;
  localparam logic [7:0]  OFF_STAT  = 8'h10;
  localparam logic [7:0]  OFF_CNT   = 8'h14;
  localparam logic        RST_EN    = 1'h0;
  localparam logic [3:0]  RST_FUNC  = 4'h0;
  localparam logic [15:0] RST_SET   = 16'h0000;
  localparam logic [2:0]  RST_TMODE = 3'h0;
  localparam logic [15:0] SET_MAX   = 16'hea60;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_DEC  = 2'h3;
  typedef enum logic [3:0] {
    FN_OFF  = 4'h0,
    FN_THRU = 4'h1,
    FN_AND  = 4'h2,
    FN_OR   = 4'h3,
    FN_XOR  = 4'h4,
    FN_SETL = 4'h5,
    FN_RSTL = 4'h6,
    FN_RISE = 4'h7,
    FN_FALL = 4'h8,
    FN_BOTH = 4'h9,
    FN_HOLD = 4'ha,
    FN_UP   = 4'hb,
    FN_DN   = 4'hc,
    FN_TMR  = 4'hd
  } pls_func_e;
endpackage
`default_nettype wire

// ### rtl/pls_step_if.sv
// Signals between the register side and the step evaluator.
// Assumes both ends run on aclk.
`timescale 1ns/1ps
`default_nettype none
interface pls_step_if;
  logic                           scan;
  logic                           en;
  logic [3:0]                     func;
  logic [15:0]                    setting;
  logic                           in1;
  logic                           in2;
  logic                           out;
  logic                           prv1;
  logic [pls_pkg::CNT_W-1:0]      cnt;
  modport core (input scan, en, func, setting, in1, in2, output out, prv1, cnt);
  modport ctl  (output scan, en, func, setting, in1, in2, input out, prv1, cnt);
endinterface
`default_nettype wire

// ### rtl/pls_step_core.sv
// Evaluator for one sequence step, updated only on the scan strobe.
// Assumes in1 and in2 are already synchronised to aclk.
`timescale 1ns/1ps
`default_nettype none
module pls_step_core (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  pls_step_if.core    s
);
  logic                      out_ff, nxt_out;
  logic                      prv1_ff, hold_ff;
  logic [pls_pkg::CNT_W-1:0] cnt_ff, nxt_cnt, tgt, lim;
  logic                      rise, fall, run;

  assign run = s.scan & s.en;
  // [RULE23] Edge against last scan
  assign rise = s.in1 & ~prv1_ff;
  assign fall = ~s.in1 & prv1_ff;
  // [RULE21] Setting is already the x100 count
  assign tgt = {4'h0, s.setting};
  assign lim = tgt * pls_pkg::CNT_W'(pls_pkg::SCANS_PER_UNIT);

  always_comb begin
    nxt_out = out_ff;
    nxt_cnt = cnt_ff;
    case (s.func)
      // [RULE1] Always off
      pls_pkg::FN_OFF:  nxt_out = 1'b0;
      // [RULE2] Straight through
      pls_pkg::FN_THRU: nxt_out = s.in1;
      // [RULE3] Two-input AND
      pls_pkg::FN_AND:  nxt_out = s.in1 & s.in2;
      // [RULE4] Two-input OR
      pls_pkg::FN_OR:   nxt_out = s.in1 | s.in2;
      // [RULE5] Two-input XOR
      pls_pkg::FN_XOR:  nxt_out = s.in1 ^ s.in2;
      // [RULE6] Set wins
      pls_pkg::FN_SETL: nxt_out = s.in1 | (~s.in2 & out_ff);
      // [RULE7] Reset wins
      pls_pkg::FN_RSTL: nxt_out = ~s.in2 & (s.in1 | out_ff);
      // [RULE8] One-scan rising pulse
      pls_pkg::FN_RISE: nxt_out = rise;
      // [RULE9] One-scan falling pulse
      pls_pkg::FN_FALL: nxt_out = fall;
      // [RULE10] One-scan pulse on any edge
      pls_pkg::FN_BOTH: nxt_out = rise | fall;
      // [RULE11] [RULE22] Input two freezes input one
      pls_pkg::FN_HOLD: nxt_out = s.in2 ? hold_ff : s.in1;
      pls_pkg::FN_UP: begin
        // [RULE13] Clear while reset
        if (s.in2) begin
          nxt_cnt = '0;
        // [RULE12] Count up, stop at target
        end else if (rise && cnt_ff != tgt) begin
          nxt_cnt = cnt_ff + pls_pkg::CNT_W'(1);
        end
        nxt_out = (nxt_cnt == tgt);
      end
      pls_pkg::FN_DN: begin
        // [RULE15] Reload while reset
        if (s.in2) begin
          nxt_cnt = tgt;
        // [RULE14] Count down to zero
        end else if (rise && cnt_ff != '0) begin
          nxt_cnt = cnt_ff - pls_pkg::CNT_W'(1);
        end
        nxt_out = (nxt_cnt == '0);
      end
      pls_pkg::FN_TMR: begin
        // [RULE18] Reset clears at once
        if (s.in2) begin
          nxt_cnt = '0;
          nxt_out = 1'b0;
        // [RULE16] Trigger starts timing
        end else if (rise) begin
          nxt_cnt = '0;
          nxt_out = 1'b1;
        // [RULE17] Off after period, trigger ignored
        end else if (out_ff) begin
          nxt_cnt = cnt_ff + pls_pkg::CNT_W'(1);
          if (nxt_cnt >= lim) begin
            nxt_out = 1'b0;
            nxt_cnt = '0;
          end
        end
      end
      default: nxt_out = 1'b0;
    endcase
  end

  // [RULE19] [RULE20] Only a running scan evaluates; disabled forces off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
    end else if (s.scan && !s.en) begin
      out_ff <= 1'b0;
    end else if (run) begin
      out_ff <= nxt_out;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (run) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // [RULE23] Sample inputs once per scan
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prv1_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (run) begin
      prv1_ff <= s.in1;
      if (!s.in2) begin
        hold_ff <= s.in1;
      end
    end
  end

  assign s.out  = out_ff;
  assign s.prv1 = prv1_ff;
  assign s.cnt  = cnt_ff;
endmodule
`default_nettype wire

// ### rtl/pls_step.sv
// One programmable logic step with its AXI4-Lite register port.
// Assumes in1_pin and in2_pin are asynchronous; one aclk domain.
`timescale 1ns/1ps
`default_nettype none
module pls_step #(
  parameter int unsigned SCAN_CYCLES_P = pls_pkg::SCAN_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        in1_pin,
  input  wire logic        in2_pin,
  output logic             step_out
);
  pls_step_if sif ();

  logic        sequence_enable_setting_ff;
  logic [3:0]  step_function_select_ff;
  logic [15:0] step_period_or_count_setting_ff;
  logic [2:0]  step_timer_mode_select_ff;
  logic [1:0]  in1_sync_ff;
  logic [1:0]  in2_sync_ff;
  logic [15:0] scan_cnt_ff;
  logic        scan;
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        do_wr;
  logic [7:0]  wa;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [31:0] set_wr;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  stb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction

  // Pins are asynchronous; second stage is the only reader of the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in1_sync_ff <= 2'h0;
      in2_sync_ff <= 2'h0;
    end else begin
      in1_sync_ff <= {in1_sync_ff[0], in1_pin};
      in2_sync_ff <= {in2_sync_ff[0], in2_pin};
    end
  end

  // [RULE19] Scan strobe every 2 ms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_cnt_ff <= 16'h0000;
    end else if (scan) begin
      scan_cnt_ff <= 16'h0000;
    end else begin
      scan_cnt_ff <= scan_cnt_ff + 16'h0001;
    end
  end

  assign scan = (scan_cnt_ff == 16'(SCAN_CYCLES_P - 1));

  assign sif.scan    = scan;
  assign sif.en      = sequence_enable_setting_ff;
  assign sif.func    = step_function_select_ff;
  assign sif.setting = step_period_or_count_setting_ff;
  assign sif.in1     = in1_sync_ff[1];
  assign sif.in2     = in2_sync_ff[1];

  pls_step_core u_core (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s       (sif.core)
  );

  // The general-purpose timer stage sits downstream; here it passes on
  assign step_out = sif.out;

  // Address and data are accepted in either order and held until paired
  assign awready = ~aw_have_ff & ~bvalid_ff;
  assign wready  = ~w_have_ff & ~bvalid_ff;
  assign do_wr   = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wa      = word_addr(awaddr_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_have_ff <= 1'b1;
      awaddr_ff  <= awaddr;
    end else if (do_wr) begin
      aw_have_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (wvalid && wready) begin
      w_have_ff <= 1'b1;
      wdata_ff  <= wdata;
      wstrb_ff  <= wstrb;
    end else if (do_wr) begin
      w_have_ff <= 1'b0;
    end
  end

  // [RULE20] Sequence enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sequence_enable_setting_ff <= pls_pkg::RST_EN;
    end else if (do_wr && wa == pls_pkg::OFF_CTRL && wstrb_ff[0]) begin
      sequence_enable_setting_ff <= wdata_ff[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_function_select_ff <= pls_pkg::RST_FUNC;
    end else if (do_wr && wa == pls_pkg::OFF_FUNC && wstrb_ff[0]) begin
      step_function_select_ff <= wdata_ff[3:0];
    end
  end

  // [RULE21] Setting held as hundredths, capped at 600.00
  assign set_wr = merge({16'h0000, step_period_or_count_setting_ff}, wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_period_or_count_setting_ff <= pls_pkg::RST_SET;
    end else if (do_wr && wa == pls_pkg::OFF_SET) begin
      if (set_wr > {16'h0000, pls_pkg::SET_MAX}) begin
        step_period_or_count_setting_ff <= pls_pkg::SET_MAX;
      end else begin
        step_period_or_count_setting_ff <= set_wr[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_timer_mode_select_ff <= pls_pkg::RST_TMODE;
    end else if (do_wr && wa == pls_pkg::OFF_TMODE && wstrb_ff[0]) begin
      step_timer_mode_select_ff <= wdata_ff[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= pls_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      if (wa == pls_pkg::OFF_CTRL || wa == pls_pkg::OFF_FUNC ||
          wa == pls_pkg::OFF_SET || wa == pls_pkg::OFF_TMODE) begin
        bresp_ff <= pls_pkg::RESP_OKAY;
      end else begin
        bresp_ff <= pls_pkg::RESP_DEC;
      end
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (word_addr(araddr) == pls_pkg::OFF_CTRL) begin
      rd_val[0] = sequence_enable_setting_ff;
    end else if (word_addr(araddr) == pls_pkg::OFF_FUNC) begin
      rd_val[3:0] = step_function_select_ff;
    end else if (word_addr(araddr) == pls_pkg::OFF_SET) begin
      rd_val[15:0] = step_period_or_count_setting_ff;
    end else if (word_addr(araddr) == pls_pkg::OFF_TMODE) begin
      rd_val[2:0] = step_timer_mode_select_ff;
    end else if (word_addr(araddr) == pls_pkg::OFF_STAT) begin
      rd_val[2:0] = {sif.in2, sif.in1, sif.out};
    end else if (word_addr(araddr) == pls_pkg::OFF_CNT) begin
      rd_val[pls_pkg::CNT_W-1:0] = sif.cnt;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign arready = ~rvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= pls_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= rd_hit ? pls_pkg::RESP_OKAY : pls_pkg::RESP_DEC;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

  scan_gap_a: assert property ( // [RULE19]
    @(posedge aclk) disable iff (!aresetn)
    scan |=> !scan [*8])
    else $error("scan strobes too close");

  seq_off_a: assert property ( // [RULE20]
    @(posedge aclk) disable iff (!aresetn)
    scan && !sif.en |=> !sif.out ##1 ($stable(sif.out) && !sif.out))
    else $error("disabled sequence drove output");

  func_off_a: assert property ( // [RULE1]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_OFF |=> !sif.out)
    else $error("code 0 output not off");

  thru_a: assert property ( // [RULE2]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_THRU |=> sif.out == $past(sif.in1))
    else $error("pass-through mismatch");

  and_gate_a: assert property ( // [RULE3]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_AND
    |=> sif.out == ($past(sif.in1) & $past(sif.in2)))
    else $error("AND result wrong");

  xor_gate_a: assert property ( // [RULE5]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_XOR
    |=> sif.out == ($past(sif.in1) ^ $past(sif.in2)))
    else $error("XOR result wrong");

  set_latch_a: assert property ( // [RULE6]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_SETL && sif.in1 |=> sif.out)
    else $error("set priority latch did not set");

  rst_latch_a: assert property ( // [RULE7]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_RSTL && sif.in2 |=> !sif.out)
    else $error("reset priority latch did not clear");

  rise_pulse_a: assert property ( // [RULE8]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_RISE && sif.in1 && !sif.prv1
    |=> sif.out ##1 (sif.out && !scan) [*7])
    else $error("rising edge pulse missing");

  up_clear_a: assert property ( // [RULE13]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_UP && sif.in2 |=> sif.cnt == '0)
    else $error("up counter not cleared");

  tmr_reset_a: assert property ( // [RULE18]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_TMR && sif.in2
    |=> !sif.out && sif.cnt == '0)
    else $error("timer reset did not clear");

  or_gate_a: assert property ( // [RULE4]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_OR
    |=> sif.out == ($past(sif.in1) | $past(sif.in2)))
    else $error("OR result wrong");

  fall_pulse_a: assert property ( // [RULE9]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_FALL && !sif.in1 && sif.prv1
    |=> sif.out ##1 (sif.out && !scan) [*7])
    else $error("falling edge pulse missing");

  both_pulse_a: assert property ( // [RULE10]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_BOTH && sif.in1 != sif.prv1
    |=> sif.out)
    else $error("either edge pulse missing");

  hold_pass_a: assert property ( // [RULE11]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_HOLD && !sif.in2
    |=> sif.out == $past(sif.in1))
    else $error("hold did not pass input");

  up_target_a: assert property ( // [RULE12]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_UP
    |=> sif.out == (sif.cnt == {4'h0, $past(sif.setting)}))
    else $error("up counter output wrong");

  dn_zero_a: assert property ( // [RULE14]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_DN
    |=> sif.out == (sif.cnt == '0))
    else $error("down counter output wrong");

  dn_reload_a: assert property ( // [RULE15]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_DN && sif.in2
    |=> sif.cnt == {4'h0, $past(sif.setting)})
    else $error("down counter not reloaded");

  tmr_start_a: assert property ( // [RULE16]
    @(posedge aclk) disable iff (!aresetn)
    scan && sif.en && sif.func == pls_pkg::FN_TMR && !sif.in2 && sif.in1 && !sif.prv1
    |=> sif.out && (sif.cnt == '0))
    else $error("timer did not start");
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for one sequence step, driven over AXI4-Lite and pins.
// Assumes pls_step with a short scan of SC cycles on a 20 MHz aclk.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SC = 20;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        in1_pin, in2_pin, step_out;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_errors, total_checks;

  pls_step #(.SCAN_CYCLES_P(SC)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .in1_pin(in1_pin),
    .in2_pin(in2_pin), .step_out(step_out));

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("unexpected timeout at %0t: exp %h got %h", $time, 1'h1, 1'h0);
    give_verdict();
  endtask

  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_bit(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ta, tw, tr;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tr = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr === 1'b1) begin
        bready <= 1'b0;
        chk_word({30'h0, er}, {30'h0, r});
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ta, tr;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr === 1'b1) begin
        rready <= 1'b0;
        chk_word(ed, d);
        chk_word({30'h0, er}, {30'h0, r});
        return;
      end
    end
    hang();
  endtask

  // Counts high cycles of the output after a pin change
  task automatic pin_cnt(input logic a, input logic b, input int n, output int c);
    @(posedge aclk);
    in1_pin <= a;
    in2_pin <= b;
    c = 0;
    repeat (n) begin
      @(negedge aclk);
      if (step_out === 1'b1) c++;
    end
  endtask

  // Long enough for sync flops plus two full scans either way
  task automatic pins(input logic a, input logic b);
    int c;
    pin_cnt(a, b, 2 * SC + 4, c);
  endtask

  function automatic logic comb_exp(input int f, input logic a, input logic b);
    case (f)
      0: return 1'b0;
      1: return a;
      2: return a & b;
      3: return a | b;
      default: return a ^ b;
    endcase
  endfunction

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end

  initial begin
    int c;
    logic [5:0] sa, sb, e5, e6;
    sa = 6'h05;
    sb = 6'h14;
    e5 = 6'h0f;
    e6 = 6'h03;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {in1_pin, in2_pin, awaddr, araddr, wdata, wstrb} = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pls_pkg::OFF_CTRL, 32'h0, pls_pkg::RESP_OKAY);
    rd(pls_pkg::OFF_FUNC, 32'h0, pls_pkg::RESP_OKAY);
    rd(pls_pkg::OFF_SET, 32'h0, pls_pkg::RESP_OKAY);
    wr(pls_pkg::OFF_TMODE, 32'h7, pls_pkg::RESP_OKAY);
    rd(pls_pkg::OFF_TMODE, 32'h7, pls_pkg::RESP_OKAY);
    wr(pls_pkg::OFF_SET, 32'hffff, pls_pkg::RESP_OKAY);
    rd(pls_pkg::OFF_SET, 32'hea60, pls_pkg::RESP_OKAY);
    wr(8'h40, 32'h1, pls_pkg::RESP_DEC);
    rd(8'h40, 32'h0, pls_pkg::RESP_DEC);
    wr(pls_pkg::OFF_FUNC, 32'h1, pls_pkg::RESP_OKAY);
    pins(1'b1, 1'b0);
    chk_bit(1'b0, step_out);
    wr(pls_pkg::OFF_CTRL, 32'h1, pls_pkg::RESP_OKAY);
    pins(1'b1, 1'b0);
    chk_bit(1'b1, step_out);
    rd(pls_pkg::OFF_STAT, 32'h3, pls_pkg::RESP_OKAY);
    for (int f = 0; f < 5; f++) begin
      wr(pls_pkg::OFF_FUNC, f, pls_pkg::RESP_OKAY);
      for (int v = 0; v < 4; v++) begin
        pins(v[0], v[1]);
        chk_bit(comb_exp(f, v[0], v[1]), step_out);
      end
    end
    for (int f = 5; f < 7; f++) begin
      wr(pls_pkg::OFF_FUNC, f, pls_pkg::RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
        pins(sa[i], sb[i]);
        chk_bit((f == 5) ? e5[i] : e6[i], step_out);
      end
    end
    // A detected edge must light the output for exactly one scan
    for (int f = 7; f < 10; f++) begin
      wr(pls_pkg::OFF_FUNC, f, pls_pkg::RESP_OKAY);
      pin_cnt(1'b1, 1'b0, 3 * SC, c);
      chk_word((f != 8) ? SC : 0, c);
      pin_cnt(1'b0, 1'b0, 3 * SC, c);
      chk_word((f != 7) ? SC : 0, c);
    end
    wr(pls_pkg::OFF_FUNC, 32'ha, pls_pkg::RESP_OKAY);
    pins(1'b1, 1'b0);
    chk_bit(1'b1, step_out);
    pins(1'b0, 1'b1);
    chk_bit(1'b1, step_out);
    pins(1'b0, 1'b0);
    chk_bit(1'b0, step_out);
    wr(pls_pkg::OFF_SET, 32'h3, pls_pkg::RESP_OKAY);
    wr(pls_pkg::OFF_FUNC, 32'hb, pls_pkg::RESP_OKAY);
    pins(1'b0, 1'b1);
    rd(pls_pkg::OFF_CNT, 32'h0, pls_pkg::RESP_OKAY);
    for (int k = 1; k < 4; k++) begin
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      chk_bit(k == 3, step_out);
    end
    rd(pls_pkg::OFF_CNT, 32'h3, pls_pkg::RESP_OKAY);
    pins(1'b0, 1'b1);
    chk_bit(1'b0, step_out);
    rd(pls_pkg::OFF_CNT, 32'h0, pls_pkg::RESP_OKAY);
    wr(pls_pkg::OFF_SET, 32'h2, pls_pkg::RESP_OKAY);
    wr(pls_pkg::OFF_FUNC, 32'hc, pls_pkg::RESP_OKAY);
    pins(1'b0, 1'b1);
    chk_bit(1'b0, step_out);
    rd(pls_pkg::OFF_CNT, 32'h2, pls_pkg::RESP_OKAY);
    for (int k = 1; k < 3; k++) begin
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      chk_bit(k == 2, step_out);
    end
    // Period of 1 is five scans; trigger stays high past it
    wr(pls_pkg::OFF_SET, 32'h1, pls_pkg::RESP_OKAY);
    wr(pls_pkg::OFF_FUNC, 32'hd, pls_pkg::RESP_OKAY);
    pins(1'b0, 1'b1);
    pin_cnt(1'b1, 1'b0, 8 * SC, c);
    chk_word(5 * SC, c);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
    chk_bit(1'b1, step_out);
    pins(1'b1, 1'b1);
    chk_bit(1'b0, step_out);
    rd(pls_pkg::OFF_CNT, 32'h0, pls_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule
`default_nettype wire
